// >>> logic/mul_unit_pkg.sv
// Purpose: Shared constants, kinds and decode for the low-product multiply unit
// Assumes: 32-bit instruction words, 5-bit register indices
// Notes:   Field positions are bit offsets of each field's least significant bit
package mul_unit_pkg;

	localparam int WORD_W      = 32;
	localparam int REG_IDX_W   = 5;
	localparam int REG_COUNT   = 32;
	localparam int IMM_W       = 16;
	localparam int OP_W        = 6;
	localparam int OPX_W       = 6;

	// ---------------------------------------------------------------
	// Instruction field positions
	// ---------------------------------------------------------------
	localparam int FIRST_SRC_LSB  = 27;
	localparam int SECOND_SRC_LSB = 22;
	localparam int DEST_R_LSB     = 17;
	localparam int OPX_LSB        = 11;
	localparam int IMM_LSB        = 6;
	localparam int OP_LSB         = 0;

	// ---------------------------------------------------------------
	// Encodings
	// ---------------------------------------------------------------
	localparam logic [OP_W-1:0]  OP_RTYPE = 6'h3a;
	localparam logic [OP_W-1:0]  OP_MULI  = 6'h24;
	localparam logic [OPX_W-1:0] OPX_MUL  = 6'h27;

	// Edges from the taking edge to the edge that raises done
	localparam int RESULT_LATENCY = 2;
	localparam logic [1:0] RST_SYNC_INIT = 2'h0;

	typedef enum logic [1:0] {
		KIND_NONE,
		KIND_MUL,
		KIND_MULI
	} kind_type;

	function automatic kind_type decode_kind(input logic [WORD_W-1:0] w);
		kind_type k;
		k = KIND_NONE;
		if (w[OP_LSB +: OP_W] == OP_MULI) begin
			k = KIND_MULI;
		end else if (w[OP_LSB +: OP_W] == OP_RTYPE && w[OPX_LSB +: OPX_W] == OPX_MUL) begin
			k = KIND_MUL;
		end
		return k;
	endfunction

endpackage

// >>> logic/reg_file_mem.sv
// Purpose: Register file, two read ports and one write port
// Assumes: Single clock; read data registered one edge after the address
// Notes:   No reset on the array; contents are undefined until written
`timescale 1ns/100ps
module reg_file_mem #(
	parameter int WIDTH    = 32,
	parameter int ADDR_W   = 5
) (
	input  wire logic              clk,
	input  wire logic [ADDR_W-1:0] raddr_a,
	input  wire logic [ADDR_W-1:0] raddr_b,
	output logic      [WIDTH-1:0]  rdata_a_q,
	output logic      [WIDTH-1:0]  rdata_b_q,
	input  wire logic              we,
	input  wire logic [ADDR_W-1:0] waddr,
	input  wire logic [WIDTH-1:0]  wdata
);

	initial begin
		if (WIDTH < 1 || ADDR_W < 1) begin
			$error("reg_file_mem: bad geometry");
		end
	end

	logic [WIDTH-1:0] mem [0:(1<<ADDR_W)-1];

	always_ff @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata_a_q <= mem[raddr_a];
		rdata_b_q <= mem[raddr_b];
	end

endmodule

// >>> logic/integer_multiply_low_unit.sv
// Purpose: Low-product multiply unit: register and immediate forms, with write-back
// Assumes: One clock; instr and load port driven by logic on clk
// Notes:   Unimplemented forms raise exc instead of writing; other words finish silently
//
// How it works
// - The register form writes the low 32 bits of first source times second source to dest.
// - Without register-form hardware that instruction raises the exception and writes nothing.
// - The register form is opcode 0x3a with extended opcode 0x27, fields first, second, dest.
// - The immediate form sign-extends its 16-bit immediate to 32 bits before multiplying.
// - The immediate form writes only the low 32 bits of the product to its second index field.
// - One truncated multiplier serves signed and unsigned first source alike.
// - Without immediate-form hardware that instruction raises the exception.
// - The immediate form is opcode 0x24: first source at 31:27, dest next, then the immediate.
// - In the immediate form bits 26:22 name the destination, not a source.
`timescale 1ns/100ps
module integer_multiply_low_unit
	import mul_unit_pkg::*;
#(
	parameter bit HAS_MUL  = 1'b1,
	parameter bit HAS_MULI = 1'b1
) (
	input  wire logic                 clk,
	input  wire logic                 rstn,
	input  wire logic                 instr_valid,
	input  wire logic [WORD_W-1:0]    instr,
	output logic                      ready,
	input  wire logic                 load_we,
	input  wire logic [REG_IDX_W-1:0] load_addr,
	input  wire logic [WORD_W-1:0]    load_data,
	output logic                      done,
	output logic                      wb_valid,
	output logic [REG_IDX_W-1:0]      wb_addr,
	output logic [WORD_W-1:0]         wb_data,
	output logic                      exc
);

	initial begin
		if (REG_COUNT != (1 << REG_IDX_W)) begin
			$error("integer_multiply_low_unit: register count mismatch");
		end
	end

	// ---------------------------------------------------------------
	// Reset release
	// ---------------------------------------------------------------
	logic [1:0] rst_sync_q;
	logic       rst_n_s;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rst_sync_q <= RST_SYNC_INIT;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n_s = rst_sync_q[1];

	// ---------------------------------------------------------------
	// Sequencer and write-back
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		S_IDLE,
		S_READ,
		S_EXEC
	} state_type;

	state_type             state_q, state_d;
	logic [WORD_W-1:0]     instr_q, instr_d;
	kind_type              kind_q, kind_d;
	logic                  ready_q, ready_d;
	logic                  done_q, done_d;
	logic                  wb_valid_q, wb_valid_d;
	logic [REG_IDX_W-1:0]  wb_addr_q, wb_addr_d;
	logic [WORD_W-1:0]     wb_data_q, wb_data_d;
	logic                  exc_q, exc_d;

	logic [WORD_W-1:0]     rd_a_q, rd_b_q;
	logic [WORD_W-1:0]     op_b;
	logic [WORD_W-1:0]     product_lo;
	logic [REG_IDX_W-1:0]  dest_idx;
	logic                  implemented;
	logic                  take;
	logic                  rf_we;
	logic [REG_IDX_W-1:0]  rf_waddr;
	logic [WORD_W-1:0]     rf_wdata;
	logic [IMM_W-1:0]      imm;

	assign take = instr_valid && ready_q;
	assign imm  = instr_q[IMM_LSB +: IMM_W];

	always_comb begin
		// Immediate widened by its sign bit
		op_b = (kind_q == KIND_MULI) ? {{(WORD_W-IMM_W){imm[IMM_W-1]}}, imm} : rd_b_q;
		// Truncated product is sign agnostic, so no signed path exists
		product_lo = rd_a_q * op_b;
		// Immediate form writes the second index field
		dest_idx = (kind_q == KIND_MULI) ? instr_q[SECOND_SRC_LSB +: REG_IDX_W]
			: instr_q[DEST_R_LSB +: REG_IDX_W];
		case (kind_q)
			KIND_MUL:  implemented = HAS_MUL;
			KIND_MULI: implemented = HAS_MULI;
			default:   implemented = 1'b0;
		endcase
	end

	always_comb begin
		state_d    = state_q;
		instr_d    = instr_q;
		kind_d     = kind_q;
		done_d     = 1'b0;
		wb_valid_d = 1'b0;
		wb_addr_d  = wb_addr_q;
		wb_data_d  = wb_data_q;
		exc_d      = 1'b0;
		case (state_q)
			S_IDLE: begin
				if (take) begin
					instr_d = instr;
					kind_d  = decode_kind(instr);
					state_d = S_READ;
				end
			end
			S_READ: begin
				state_d = S_EXEC;
			end
			S_EXEC: begin
				state_d = S_IDLE;
				done_d  = 1'b1;
				if (kind_q != KIND_NONE) begin
					if (implemented) begin
						wb_valid_d = 1'b1;
						wb_addr_d  = dest_idx;
						wb_data_d  = product_lo;
					end else begin
						exc_d = 1'b1;
					end
				end
			end
			default: begin
				state_d = S_IDLE;
			end
		endcase
		ready_d = (state_d == S_IDLE);
	end

	always_ff @(posedge clk or negedge rst_n_s) begin
		if (!rst_n_s) begin
			state_q    <= S_IDLE;
			instr_q    <= '0;
			kind_q     <= KIND_NONE;
			ready_q    <= 1'b0;
			done_q     <= 1'b0;
			wb_valid_q <= 1'b0;
			wb_addr_q  <= '0;
			wb_data_q  <= '0;
			exc_q      <= 1'b0;
		end else begin
			state_q    <= state_d;
			instr_q    <= instr_d;
			kind_q     <= kind_d;
			ready_q    <= ready_d;
			done_q     <= done_d;
			wb_valid_q <= wb_valid_d;
			wb_addr_q  <= wb_addr_d;
			wb_data_q  <= wb_data_d;
			exc_q      <= exc_d;
		end
	end

	assign ready    = ready_q;
	assign done     = done_q;
	assign wb_valid = wb_valid_q;
	assign wb_addr  = wb_addr_q;
	assign wb_data  = wb_data_q;
	assign exc      = exc_q;

	// ---------------------------------------------------------------
	// Register file
	// ---------------------------------------------------------------
	// Loads only land while idle, so they never race a write-back
	always_comb begin
		rf_we    = 1'b0;
		rf_waddr = load_addr;
		rf_wdata = load_data;
		if (state_q == S_EXEC) begin
			rf_we    = (kind_q != KIND_NONE) && implemented;
			rf_waddr = dest_idx;
			rf_wdata = product_lo;
		end else if (ready_q) begin
			rf_we = load_we;
		end
	end

	reg_file_mem #(
		.WIDTH  (WORD_W),
		.ADDR_W (REG_IDX_W)
	) u_regs (
		.clk       (clk),
		.raddr_a   (instr_q[FIRST_SRC_LSB +: REG_IDX_W]),
		.raddr_b   (instr_q[SECOND_SRC_LSB +: REG_IDX_W]),
		.rdata_a_q (rd_a_q),
		.rdata_b_q (rd_b_q),
		.we        (rf_we),
		.waddr     (rf_waddr),
		.wdata     (rf_wdata)
	);

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	logic signed [2*WORD_W-1:0] ref_full;
	logic [WORD_W-1:0]          ref_lo;
	logic [WORD_W-1:0]          ref_rr;

	assign ref_full = $signed({{WORD_W{rd_a_q[WORD_W-1]}}, rd_a_q})
		* $signed({{(2*WORD_W-IMM_W){imm[IMM_W-1]}}, imm});
	assign ref_lo   = ref_full[WORD_W-1:0];
	assign ref_rr   = rd_a_q * rd_b_q;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n_s);

	// Done is raised by the second edge after the take, so it is seen at the third
	a_mul_product: assert property (state_q == S_EXEC && kind_q == KIND_MUL && HAS_MUL
		|=> wb_valid && wb_data == $past(ref_rr)) else $error("register product wrong");
	a_mul_absent: assert property (state_q == S_EXEC && kind_q == KIND_MUL && !HAS_MUL
		|=> exc && !wb_valid && done) else $error("missing exception for register form");
	a_rtype_decode: assert property (take && instr[OP_LSB +: OP_W] == OP_RTYPE
		&& instr[OPX_LSB +: OPX_W] == OPX_MUL |-> ##3 done ##0 (wb_valid || exc))
		else $error("register form not completed");
	a_imm_sext: assert property (state_q == S_EXEC && kind_q == KIND_MULI
		|-> op_b[WORD_W-1:IMM_W] == {(WORD_W-IMM_W){imm[IMM_W-1]}})
		else $error("immediate not sign extended");
	a_imm_dest: assert property (take && decode_kind(instr) == KIND_MULI && HAS_MULI
		|-> ##3 wb_valid && wb_addr == $past(instr[SECOND_SRC_LSB +: REG_IDX_W], 3))
		else $error("immediate destination wrong");
	a_sign_indep: assert property (state_q == S_EXEC && kind_q == KIND_MULI && HAS_MULI
		|=> wb_data == $past(ref_lo)) else $error("immediate product differs from signed");
	a_muli_absent: assert property (state_q == S_EXEC && kind_q == KIND_MULI && !HAS_MULI
		|=> exc && !wb_valid) else $error("missing exception for immediate form");
	a_itype_fields: assert property (take && instr[OP_LSB +: OP_W] == OP_MULI
		|=> kind_q == KIND_MULI ##0 state_q == S_READ) else $error("immediate opcode missed");
	a_dest_field: assert property (state_q == S_EXEC && kind_q == KIND_MULI
		|-> rf_waddr == instr_q[SECOND_SRC_LSB +: REG_IDX_W] && rf_we == HAS_MULI)
		else $error("bits 26:22 not dest");
	a_other_opx: assert property (take && instr[OP_LSB +: OP_W] == OP_RTYPE
		&& instr[OPX_LSB +: OPX_W] != OPX_MUL |-> ##3 done && !wb_valid && !exc)
		else $error("foreign extended opcode acted on");

	c_mul_done: cover property (done && wb_valid && kind_q == KIND_MUL);
	c_muli_neg: cover property (done && wb_valid && kind_q == KIND_MULI && imm[IMM_W-1]);
	c_exc: cover property (exc);
	// Ready returns with done, so a waiting word is taken in the done cycle
	c_back_to_back: cover property (done && take);

endmodule

// >>> tb/instr_feed.sv
// Purpose: Decoder-side model that offers one word per request to the unit
// Assumes: Request is a one-cycle pulse while no word is pending
// Notes:   A word is held until taken; the bus is then scrambled, not left stale
`timescale 1ns/100ps
module instr_feed
	import mul_unit_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              rstn,
	input  wire logic              req,
	input  wire logic [WORD_W-1:0] word,
	input  wire logic              ready,
	output logic                   instr_valid,
	output logic      [WORD_W-1:0] instr
);
	// ---------------------------------------------------------------
	// Offer and hold
	// ---------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			instr_valid <= 1'b0;
			instr       <= '0;
		end else if (instr_valid && ready) begin
			// Inverted so a late sample of a released word cannot pass
			instr_valid <= 1'b0;
			instr       <= ~instr;
		end else if (req && !instr_valid) begin
			instr_valid <= 1'b1;
			instr       <= word;
		end
	end
endmodule

// >>> tb/integer_multiply_low_unit_tb.sv
// Purpose: Self-checking bench for the low-product multiply unit
// Assumes: Register mirror kept here from every load and write-back
// Notes:   A second instance lacks both forms and must trap on them
`timescale 1ns/100ps
module integer_multiply_low_unit_tb
	import mul_unit_pkg::*;
;
	logic              clk, rstn, req, iv, ready, done, wb_valid, exc;
	logic              load_we, done_b, wb_valid_b, exc_b;
	logic [4:0]        load_addr, wb_addr;
	logic [WORD_W-1:0] word, instr, load_data, wb_data, v;
	logic [WORD_W-1:0] regs [REG_COUNT];
	int                errors, check_count, n;

	instr_feed u_feed (.clk(clk), .rstn(rstn), .req(req), .word(word), .ready(ready),
		.instr_valid(iv), .instr(instr));
	integer_multiply_low_unit u_dut (.clk(clk), .rstn(rstn), .instr_valid(iv), .instr(instr),
		.ready(ready), .load_we(load_we), .load_addr(load_addr), .load_data(load_data), .done(done),
		.wb_valid(wb_valid), .wb_addr(wb_addr), .wb_data(wb_data), .exc(exc));
	integer_multiply_low_unit #(.HAS_MUL(1'b0), .HAS_MULI(1'b0)) u_dut_bare (.clk(clk), .rstn(rstn),
		.instr_valid(iv), .instr(instr), .ready(), .load_we(load_we), .load_addr(load_addr),
		.load_data(load_data), .done(done_b), .wb_valid(wb_valid_b), .wb_addr(), .wb_data(), .exc(exc_b));

	always #4 clk = ~clk;

	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	task automatic check(input logic [WORD_W-1:0] seen, input logic [WORD_W-1:0] exp);
		check_count++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic end_sim;
		$display("comparisons %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	function automatic logic [31:0] mulw(input logic [4:0] a, b, c, input logic [5:0] x);
		return {a, b, c, x, 5'h00, OP_RTYPE};
	endfunction

	function automatic logic [31:0] muliw(input logic [4:0] a, b, input logic [15:0] imm);
		return {a, b, imm, OP_MULI};
	endfunction

	// Expected write-back, worked out from the register mirror
	function automatic void model(input logic [31:0] w, output logic hit, output logic [4:0] d,
		output logic [31:0] e);
		hit = 1'b0;
		e   = '0;
		d   = '0;
		if (w[5:0] == OP_MULI) begin
			hit = 1'b1;
			d   = w[26:22];
			e   = regs[w[31:27]] * {{16{w[21]}}, w[21:6]};
		end else if (w[5:0] == OP_RTYPE && w[16:11] == OPX_MUL) begin
			hit = 1'b1;
			d   = w[21:17];
			e   = regs[w[31:27]] * regs[w[26:22]];
		end
	endfunction

	task automatic send(input logic [31:0] w);
		@(posedge clk);
		req  <= 1'b1;
		word <= w;
		@(posedge clk);
		req  <= 1'b0;
	endtask

	// Lat is one less than the count of edges still to wait for done once this task starts
	task automatic collect(input logic [31:0] w, input int lat);
		logic [31:0] e;
		logic [4:0]  d;
		logic        hit;
		model(w, hit, d, e);
		for (n = 0; n < 12; n++) begin
			@(posedge clk);
			#1;
			if (done === 1'b1) break;
		end
		if (n == 12) begin
			errors++;
			$display("mismatch at %0t: no done within 12 cycles", $time);
			end_sim();
		end else begin
			check(n, lat);
			check(ready, 1'b1);
			check(done_b, 1'b1);
			check(wb_valid, hit);
			check(exc, 1'b0);
			check(exc_b, hit);
			check(wb_valid_b, 1'b0);
			if (hit) begin
				check(wb_addr, d);
				check(wb_data, e);
				regs[d] = e;
			end
		end
	endtask

	task automatic run(input logic [31:0] w);
		send(w);
		collect(w, RESULT_LATENCY);
	endtask

	// Second word waits in the feed while the first is busy, taken in its done cycle
	task automatic pair(input logic [31:0] w1, input logic [31:0] w2);
		send(w1);
		send(w2);
		collect(w1, RESULT_LATENCY - 2);
		collect(w2, RESULT_LATENCY);
	endtask

	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial begin
		clk       = 1'b0;
		rstn      = 1'b0;
		req       = 1'b0;
		word      = '0;
		load_we   = 1'b0;
		load_addr = '0;
		load_data = '0;
		errors    = 0;
		check_count = 0;
		void'($urandom(76));
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		for (n = 0; n < 10 && ready !== 1'b1; n++) begin
			@(posedge clk);
		end
		check(ready, 1'b1);
		for (int i = 0; i < REG_COUNT; i++) begin
			v = (i == 1) ? 32'hffffffff : (i == 2) ? 32'h80000000 : $urandom;
			@(posedge clk);
			load_we   <= 1'b1;
			load_addr <= i[4:0];
			load_data <= v;
			regs[i]   = v;
		end
		@(posedge clk);
		load_we <= 1'b0;
		$display("register load done");
		run(mulw(5'd1, 5'd2, 5'd3, OPX_MUL));
		run(mulw(5'd1, 5'd1, 5'd4, OPX_MUL));
		run(muliw(5'd1, 5'd5, 16'hffff));
		run(muliw(5'd2, 5'd6, 16'h8000));
		run(muliw(5'd7, 5'd7, 16'h7fff));
		run(mulw(5'd1, 5'd2, 5'd8, 6'h1f));
		run({26'h0123456, 6'h04});
		pair(mulw(5'd1, 5'd2, 5'd9, OPX_MUL), muliw(5'd9, 5'd10, 16'hff9c));
		$display("corner cases done");
		repeat (60) begin
			v = $urandom;
			case (v[1:0])
				2'd0: run(mulw(v[31:27], v[26:22], v[21:17], OPX_MUL));
				2'd1: run(muliw(v[31:27], v[26:22], v[21:6]));
				2'd2: run({v[31:6], OP_RTYPE});
				default: run($urandom);
			endcase
		end
		$display("random mix done");
		end_sim();
	end
endmodule
